// ---- dv/lws_host.sv ----
// Behavioural LPC host that runs I/O cycles against the block.
// Assumes LAD has pull-ups, so a released bus reads 1111.
`timescale 1ns/1ns
module lws_host (
    // Clock
    input wire logic clk,
    // Block side of LAD
    input wire logic [3:0] lad_o,
    input wire logic lad_oe,
    // Host side of LAD
    output logic lframe_n,
    output logic [3:0] lad_i
);
    logic own;
    logic [3:0] drv;
    // Wire level from both drivers
    assign lad_i = lad_oe ? lad_o : (own ? drv : 4'hF);
    initial begin
        lframe_n = 1'b1;
        own = 1'b0;
        drv = 4'hF;
    end
    // One nibble, changed just after a rising edge
    task automatic put(input logic fr, input logic [3:0] n);
        @(posedge clk);
        lframe_n <= fr;
        own <= 1'b1;
        drv <= n;
    endtask
    // Whole I/O cycle; ok stays low when no target answers
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
        int i;
        q = 8'h00;
        ok = 1'b0;
        put(1'b0, 4'h0);
        put(1'b1, {2'b00, wr, 1'b0});
        for (i = 3; i >= 0; i--) begin
            put(1'b1, a[i*4 +: 4]);
        end
        if (wr) begin
            put(1'b1, d[3:0]);
            put(1'b1, d[7:4]);
        end
        put(1'b1, 4'hF);
        @(posedge clk);
        own <= 1'b0;
        // Block outputs are read mid-cycle, where they have settled
        for (i = 0; i < 6 && !ok; i++) begin
            @(negedge clk);
            ok = lad_oe && lad_o == 4'h0;
        end
        if (ok && !wr) begin
            @(negedge clk);
            q[3:0] = lad_o;
            @(negedge clk);
            q[7:4] = lad_o;
        end
        // Wait out the turnaround nibble so the next frame finds LAD released
        if (ok) begin
            repeat (2) @(negedge clk);
        end
    endtask
    // Read cycle cut by a frame start while the block drives; held reports LAD still driven after it
    task automatic cut(input logic [15:0] a, output logic held);
        int i;
        put(1'b0, 4'h0);
        put(1'b1, 4'h0);
        for (i = 3; i >= 0; i--) begin
            put(1'b1, a[i*4 +: 4]);
        end
        put(1'b1, 4'hF);
        @(posedge clk);
        own <= 1'b0;
        repeat (2) @(posedge clk);
        lframe_n <= 1'b0;
        @(posedge clk);
        lframe_n <= 1'b1;
        @(negedge clk);
        held = lad_oe;
    endtask
endmodule

// ---- dv/lws_props_properties.sv ----
// Checker on the top ports of the LPC watchdog block.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ns
module lws_props #(
    parameter int unsigned STEP_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // LPC bus
    input wire logic lframe_n,
    input wire logic [3:0] lad_i,
    input wire logic [3:0] lad_o,
    input wire logic lad_oe,
    // Board pins
    input wire logic [4:0] slot_pos_pins,
    input wire logic [7:0] progress_code_leds,
    input wire logic board_reset,
    input wire logic wdt_armed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus turnaround and framing
    property p_sync_first;
        $rose(lad_oe) |-> lad_o == 4'h0;
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("drive opened without sync");
    // Read data may itself hold 1111, so judge a release by the nibble before it; aborts excluded
    property p_release;
        $fell(lad_oe) && $past(lframe_n) |-> $past(lad_o) == 4'hF;
    endproperty
    a_release: assert property (p_release) else $error("bus released without a turnaround nibble");
    // Write answers last two clocks and read answers four
    property p_drive_ends;
        $rose(lad_oe) |-> ##[2:4] !lad_oe;
    endproperty
    a_drive_ends: assert property (p_drive_ends) else $error("bus held past the answer");
    property p_abort;
        !lframe_n |=> !lad_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("bus driven after frame start");
    // Latch moves only at the end of a claimed write
    property p_leds;
        !$stable(progress_code_leds) |-> lad_oe || $past(lad_oe);
    endproperty
    a_leds: assert property (p_leds) else $error("code leds changed outside a write");
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    // Cycles spent armed; a refresh keeps counting, so this only bounds expiry from below
    int armed_cycles;
    always_ff @(posedge clk) begin
        if (!rst_n || !wdt_armed) begin
            armed_cycles <= 0;
        end else begin
            armed_cycles <= armed_cycles + 1;
        end
    end
    property p_full_second;
        $rose(board_reset) |-> armed_cycles >= STEP_CYCLES;
    endproperty
    a_full_second: assert property (p_full_second) else $error("board reset before one whole second");
    property p_arm;
        $rose(wdt_armed) |-> $past(lad_oe) && $past(lad_o) == 4'hF;
    endproperty
    a_arm: assert property (p_arm) else $error("armed without a write");
    property p_disarm;
        $fell(wdt_armed) |-> board_reset || $past(lad_oe) || $past(lad_oe, 2) || $past(lad_oe, 3);
    endproperty
    a_disarm: assert property (p_disarm) else $error("disarmed without cause");
    property p_expiry;
        $rose(board_reset) |-> !wdt_armed && $past(wdt_armed);
    endproperty
    a_expiry: assert property (p_expiry) else $error("reset not from an armed timer");
    // Fifteen cycles high, split to keep the repetitions short
    property p_pulse;
        $rose(board_reset) |-> board_reset[*8] ##1 board_reset[*7] ##1 !board_reset;
    endproperty
    a_pulse: assert property (p_pulse) else $error("board reset pulse length wrong");
endmodule
bind lws_top lws_props #(.STEP_CYCLES(STEP_CYCLES)) i_props (
    .clk(clk), .rst_n(rst_n), .lframe_n(lframe_n), .lad_i(lad_i), .lad_o(lad_o), .lad_oe(lad_oe),
    .slot_pos_pins(slot_pos_pins), .progress_code_leds(progress_code_leds), .board_reset(board_reset),
    .wdt_armed(wdt_armed)
);

// ---- dv/lws_top_tb.sv ----
// Self-checking bench for the LPC watchdog block.
// Assumes a short prescaler so each second is STEP clocks.
`timescale 1ns/1ns
module lws_top_tb;
    localparam int STEP = 10;
    logic clk;
    logic rst_n;
    logic lframe_n;
    logic [3:0] lad_i;
    logic [3:0] lad_o;
    logic lad_oe;
    logic [4:0] slot_pos_pins;
    logic [7:0] progress_code_leds;
    logic board_reset;
    logic wdt_armed;
    logic [7:0] q;
    logic ok;
    int mismatches;
    int n_compared;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    lws_top #(.STEP_CYCLES(STEP)) i_dut (.clk(clk), .rst_n(rst_n), .lframe_n(lframe_n), .lad_i(lad_i),
        .lad_o(lad_o), .lad_oe(lad_oe), .slot_pos_pins(slot_pos_pins),
        .progress_code_leds(progress_code_leds), .board_reset(board_reset), .wdt_armed(wdt_armed));
    lws_host i_host (.clk(clk), .lad_o(lad_o), .lad_oe(lad_oe), .lframe_n(lframe_n), .lad_i(lad_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bus cycle, then one more clock so the arm pulse has reached the timer
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        i_host.io(wr, a, d, q, ok);
        @(negedge clk);
    endtask
    // Reports whether board reset shows within n cycles
    task automatic watch(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk);
            seen = seen | (board_reset === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_post;
        bus(1'b1, 16'h0080, 8'hA5);
        check(progress_code_leds, 8'hA5);
        bus(1'b0, 16'h0080, 8'h00);
        check(q, 8'hA5);
        $display("post code test done");
    endtask
    task automatic t_ident;
        logic [4:0] pv [2] = '{5'h15, 5'h0A};
        bus(1'b0, 16'h0445, 8'h00);
        check(q, 8'h10);
        foreach (pv[i]) begin
            @(posedge clk);
            slot_pos_pins <= pv[i];
            repeat (6) @(posedge clk);
            bus(1'b0, 16'h0447, 8'h00);
            check(q, {3'b111, pv[i]});
        end
        $display("identity test done");
    endtask
    task automatic t_decode;
        bus(1'b0, 16'h0446, 8'h00);
        check({7'h00, ok}, 8'h00);
        bus(1'b1, 16'h0443, 8'h00);
        check({7'h00, wdt_armed}, 8'h00);
        i_host.cut(16'h0445, ok);
        check({7'h00, ok}, 8'h00);
        $display("decode test done");
    endtask
    // A three-second and the longest interval, timed from the arming write
    task automatic t_expire;
        logic [7:0] iv [2] = '{8'h03, 8'hFF};
        int n;
        foreach (iv[i]) begin
            bus(1'b1, 16'h0443, iv[i]);
            check({7'h00, wdt_armed}, 8'h01);
            n = 0;
            while (board_reset !== 1'b1 && n < 3000) begin
                @(negedge clk);
                n++;
            end
            if (n == 3000) begin
                mismatches++;
                end_of_test();
            end
            check({7'h00, n + 4 >= iv[i] * STEP && n <= iv[i] * STEP + 2}, 8'h01);
            check({7'h00, wdt_armed}, 8'h00);
            repeat (20) @(posedge clk);
        end
        $display("expiry test done");
    endtask
    // Refresh lands before the first deadline and the second watch runs past it; disarm then holds it off
    task automatic t_refresh;
        logic s1;
        logic s2;
        bus(1'b1, 16'h0443, 8'h03);
        watch(5, s1);
        bus(1'b1, 16'h0443, 8'h03);
        watch(12, s2);
        check({7'h00, s1 | s2}, 8'h00);
        bus(1'b0, 16'h0444, 8'h00);
        check({7'h00, wdt_armed}, 8'h00);
        watch(40, s1);
        check({7'h00, s1}, 8'h00);
        $display("refresh test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        slot_pos_pins = 5'h00;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({7'h00, wdt_armed}, 8'h00);
        t_post();
        t_ident();
        t_decode();
        t_expire();
        t_refresh();
        end_of_test();
    end
endmodule

// ---- logic/lws_defs.svh ----
// Constants for the LPC watchdog and status register block.
// Assumes inclusion by bare name from any file of the block.
`ifndef LWS_DEFS_SVH
`define LWS_DEFS_SVH

// I/O addresses decoded on the LPC bus
`define LWS_ADDR_POST 16'h0080
`define LWS_ADDR_ARM 16'h0443
`define LWS_ADDR_DISARM 16'h0444
`define LWS_ADDR_VERSION 16'h0445
`define LWS_ADDR_SLOT 16'h0447

// Slot register fixed upper bits
`define LWS_SLOT_FIXED 3'h7

// LPC field encodings
`define LWS_LAD_START 4'h0
`define LWS_LAD_SYNC_OK 4'h0
`define LWS_LAD_TAR 4'hF
`define LWS_CT_IO_RD 3'h0
`define LWS_CT_IO_WR 3'h1

// Watchdog timing: one step is one second of a 100 ns clock
`define LWS_STEP_MS 1000
`define LWS_CLK_NS 100
`define LWS_STEP_CYCLES ((`LWS_STEP_MS * 1000000) / `LWS_CLK_NS)

// Board reset pulse length in clock cycles
`define LWS_RST_PULSE_CYCLES 4'hF

`endif

// ---- logic/lws_pkg.sv ----
// Types shared by the LPC watchdog and status register block.
// Assumes nothing of its surroundings.
package lws_pkg;

    // LPC target cycle phases
    typedef enum logic [3:0] {
        LWS_IDLE,
        LWS_CYC,
        LWS_ADDR,
        LWS_WDATA,
        LWS_HTAR,
        LWS_SYNC,
        LWS_RDATA,
        LWS_DTAR
    } lws_lpc_st_e;

    // All state of the top module
    typedef struct packed {
        lws_lpc_st_e st;
        logic [1:0] cnt;
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
        logic [3:0] lad_o;
        logic lad_oe;
        logic [7:0] post;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] slot;
        logic arm;
        logic disarm;
        logic [7:0] interval;
    } lws_top_s;

    // All state of the watchdog timer
    typedef struct packed {
        logic armed;
        logic [7:0] secs;
        logic [23:0] pre;
        logic [3:0] rst_cnt;
    } lws_wdt_s;

endpackage

// ---- logic/lws_top.sv ----
// LPC I/O target with post code latch, watchdog, version and slot position.
// Assumes the LPC bus runs on clk and the host follows LPC I/O cycle framing.
`timescale 1ns/1ns
`include "lws_defs.svh"

module lws_top #(
    parameter logic [3:0] VERSION_UNITS = 4'h1,
    parameter logic [3:0] VERSION_TENTHS = 4'h0,
    parameter int unsigned STEP_CYCLES = `LWS_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // LPC bus
    input wire logic lframe_n,
    input wire logic [3:0] lad_i,
    output logic [3:0] lad_o,
    output logic lad_oe,
    // Backplane slot address pins, bit 4 is slot_pos_msb, bit 0 slot_pos_lsb
    input wire logic [4:0] slot_pos_pins,
    // Board outputs
    output logic [7:0] progress_code_leds,
    output logic board_reset,
    output logic wdt_armed
);

    lws_pkg::lws_top_s r;
    lws_pkg::lws_top_s next_r;
    logic [15:0] addr_next;
    logic hit;
    logic [7:0] rd_mux;

    lws_wdt_if wdt ();

    ////////////////////////////////////////////////////////////////////////
    // Address as it stands after the current nibble
    assign addr_next = {r.addr[11:0], lad_i};

    // Claim only our own ports, so other targets can answer the rest
    always_comb begin
        if (r.wr) begin
            hit = (addr_next == `LWS_ADDR_POST) || (addr_next == `LWS_ADDR_ARM);
        end else begin
            hit = (addr_next == `LWS_ADDR_POST) || (addr_next == `LWS_ADDR_DISARM)
                || (addr_next == `LWS_ADDR_VERSION) || (addr_next == `LWS_ADDR_SLOT);
        end
    end

    // Read data for the decoded address
    always_comb begin
        case (addr_next)
            `LWS_ADDR_POST: rd_mux = r.post;
            `LWS_ADDR_VERSION: rd_mux = {VERSION_UNITS, VERSION_TENTHS};
            `LWS_ADDR_SLOT: rd_mux = {`LWS_SLOT_FIXED, r.slot};
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: pin synchroniser, LPC cycle sequencer, register effects
    always_comb begin
        next_r = r;
        next_r.arm = 1'b0;
        next_r.disarm = 1'b0;

        // Slot pins are asynchronous; accept a value once two stages agree
        next_r.s1 = slot_pos_pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.slot = r.s3;
        end

        if (!lframe_n) begin
            // A frame start aborts anything in progress; last start nibble wins
            next_r.lad_oe = 1'b0;
            next_r.cnt = 2'h0;
            if (lad_i == `LWS_LAD_START) begin
                next_r.st = lws_pkg::LWS_CYC;
            end else begin
                next_r.st = lws_pkg::LWS_IDLE;
            end
        end else begin
            case (r.st)
                lws_pkg::LWS_IDLE: begin
                    next_r.lad_oe = 1'b0;
                end
                lws_pkg::LWS_CYC: begin
                    // Only I/O reads and writes are ours
                    next_r.cnt = 2'h0;
                    if (lad_i[3:1] == `LWS_CT_IO_WR) begin
                        next_r.wr = 1'b1;
                        next_r.st = lws_pkg::LWS_ADDR;
                    end else if (lad_i[3:1] == `LWS_CT_IO_RD) begin
                        next_r.wr = 1'b0;
                        next_r.st = lws_pkg::LWS_ADDR;
                    end else begin
                        next_r.st = lws_pkg::LWS_IDLE;
                    end
                end
                lws_pkg::LWS_ADDR: begin
                    // Four nibbles, most significant first
                    next_r.addr = addr_next;
                    next_r.cnt = r.cnt + 2'h1;
                    if (r.cnt == 2'h3) begin
                        next_r.cnt = 2'h0;
                        if (!hit) begin
                            next_r.st = lws_pkg::LWS_IDLE;
                        end else if (r.wr) begin
                            next_r.st = lws_pkg::LWS_WDATA;
                        end else begin
                            next_r.data = rd_mux;
                            next_r.st = lws_pkg::LWS_HTAR;
                        end
                    end
                end
                lws_pkg::LWS_WDATA: begin
                    // Data arrives low nibble first
                    if (r.cnt == 2'h0) begin
                        next_r.data[3:0] = lad_i;
                        next_r.cnt = 2'h1;
                    end else begin
                        next_r.data[7:4] = lad_i;
                        next_r.cnt = 2'h0;
                        next_r.st = lws_pkg::LWS_HTAR;
                    end
                end
                lws_pkg::LWS_HTAR: begin
                    // Two turnaround clocks owned by the host
                    if (r.cnt == 2'h0) begin
                        next_r.cnt = 2'h1;
                    end else begin
                        next_r.cnt = 2'h0;
                        next_r.lad_o = `LWS_LAD_SYNC_OK;
                        next_r.lad_oe = 1'b1;
                        next_r.st = lws_pkg::LWS_SYNC;
                    end
                end
                lws_pkg::LWS_SYNC: begin
                    // Effects land on the ready sync, once per cycle
                    if (r.wr) begin
                        if (r.addr == `LWS_ADDR_POST) begin
                            next_r.post = r.data;
                        end
                        if ((r.addr == `LWS_ADDR_ARM) && (r.data != 8'h00)) begin
                            next_r.arm = 1'b1;
                            next_r.interval = r.data;
                        end
                        next_r.lad_o = `LWS_LAD_TAR;
                        next_r.st = lws_pkg::LWS_DTAR;
                    end else begin
                        if (r.addr == `LWS_ADDR_DISARM) begin
                            next_r.disarm = 1'b1;
                        end
                        next_r.lad_o = r.data[3:0];
                        next_r.cnt = 2'h0;
                        next_r.st = lws_pkg::LWS_RDATA;
                    end
                end
                lws_pkg::LWS_RDATA: begin
                    if (r.cnt == 2'h0) begin
                        next_r.lad_o = r.data[7:4];
                        next_r.cnt = 2'h1;
                    end else begin
                        next_r.lad_o = `LWS_LAD_TAR;
                        next_r.cnt = 2'h0;
                        next_r.st = lws_pkg::LWS_DTAR;
                    end
                end
                lws_pkg::LWS_DTAR: begin
                    // Drive ones for one clock, then release the bus
                    next_r.lad_oe = 1'b0;
                    next_r.st = lws_pkg::LWS_IDLE;
                end
                default: begin
                    next_r.lad_oe = 1'b0;
                    next_r.st = lws_pkg::LWS_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog timer
    assign wdt.arm = r.arm;
    assign wdt.disarm = r.disarm;
    assign wdt.interval = r.interval;

    lws_wdt #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_wdt (
        .clk(clk),
        .rst_n(rst_n),
        .wdt(wdt)
    );

    // Outputs from flip-flops; board_reset decodes the pulse counter
    assign lad_o = r.lad_o;
    assign lad_oe = r.lad_oe;
    assign progress_code_leds = r.post;
    assign board_reset = wdt.expired;
    assign wdt_armed = wdt.armed;

endmodule

// ---- logic/lws_wdt.sv ----
// Seconds watchdog: prescaler, countdown and board reset pulse.
// Assumes arm and disarm are one-cycle pulses on clk and never coincide.
`timescale 1ns/1ns
`include "lws_defs.svh"
module lws_wdt #(
    parameter int unsigned STEP_CYCLES = `LWS_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the register decoder
    lws_wdt_if.timer wdt
);

    lws_pkg::lws_wdt_s r;
    lws_pkg::lws_wdt_s next_r;
    logic step;

    ////////////////////////////////////////////////////////////////////////
    // One-second enable; counting only while armed keeps the phase fresh
    assign step = r.armed && (r.pre == 24'(STEP_CYCLES - 1));

    // Next state
    always_comb begin
        next_r = r;
        if (r.rst_cnt != 4'h0) begin
            next_r.rst_cnt = r.rst_cnt - 4'h1;
        end
        if (r.armed) begin
            next_r.pre = step ? 24'h00_0000 : r.pre + 24'h00_0001;
        end
        // A refresh landing on the expiry step wins, so no board reset follows it
        if (step && !(wdt.arm && (wdt.interval != 8'h00))) begin
            // Expiry after exactly the programmed number of seconds
            if (r.secs == 8'h01) begin
                next_r.armed = 1'b0;
                next_r.rst_cnt = `LWS_RST_PULSE_CYCLES;
                next_r.secs = 8'h00;
            end else begin
                next_r.secs = r.secs - 8'h01;
            end
        end
        if (wdt.disarm) begin
            next_r.armed = 1'b0;
            next_r.pre = 24'h00_0000;
        end
        if (wdt.arm && (wdt.interval != 8'h00)) begin
            // Refresh restarts the full interval and a fresh second
            next_r.armed = 1'b1;
            next_r.secs = wdt.interval;
            next_r.pre = 24'h00_0000;
        end
    end

    // State register; disarmed after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign wdt.armed = r.armed;
    assign wdt.expired = (r.rst_cnt != 4'h0);

endmodule

// ---- logic/lws_wdt_if.sv ----
// Link between the register decoder and the watchdog timer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface lws_wdt_if;
    logic arm;
    logic disarm;
    logic [7:0] interval;
    logic armed;
    logic expired;

    modport ctrl (output arm, output disarm, output interval, input armed, input expired);
    modport timer (input arm, input disarm, input interval, output armed, output expired);
endinterface
